// file: pkg/tpsc_pkg.sv
package tpsc_pkg;

    // ----------------------------------------------------------------
    // register offsets on the serial programming port
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CBD = 8'h48;   // balance disable time
    localparam logic [7:0] ADDR_QUICK = 8'h49; // quick response / overshoot
    localparam logic [7:0] ADDR_SHED = 8'h4A;  // deglitch / low pulse
    localparam logic [7:0] ADDR_SCR = 8'h4B;   // customer scratch
    localparam logic [7:0] ADDR_RFPD = 8'h4C;  // ref filter / pull-down
    localparam logic [7:0] ADDR_OCP = 8'h4D;   // per-phase overcurrent

    // value of the global lock register that freezes the bank
    localparam logic [7:0] LOCK_CODE = 8'hA6;

    // ----------------------------------------------------------------
    // reset values and writable bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CBD = 8'h0B;
    localparam logic [7:0] RST_QUICK = 8'h5B;
    localparam logic [7:0] RST_SHED = 8'h13;
    localparam logic [7:0] RST_SCR = 8'h00;
    localparam logic [7:0] RST_RFPD = 8'h2A;
    localparam logic [7:0] RST_OCP = 8'h00;
    localparam logic [7:0] MASK_CBD = 8'h0F;
    localparam logic [7:0] MASK_QUICK = 8'hFF;
    localparam logic [7:0] MASK_SHED = 8'h3F;
    localparam logic [7:0] MASK_SCR = 8'hFF;
    localparam logic [7:0] MASK_RFPD = 8'h7F;
    localparam logic [7:0] MASK_OCP = 8'h03;

    // ----------------------------------------------------------------
    // field positions (lsb of each field)
    // ----------------------------------------------------------------
    localparam int QUICK_WIDTH_LSB = 6;
    localparam int QUICK_THR_LSB = 3;
    localparam int AO_THR_LSB = 0;
    localparam int DEG_LSB = 3;
    localparam int LOWP_LSB = 0;
    localparam int RF_LSB = 5;
    localparam int PD_CCM_LSB = 2;
    localparam int PD_DCM_LSB = 0;
    localparam int OCP_ANA_BIT = 1;
    localparam int OCP_FLAG_BIT = 0;

    // quick-response width selector codes
    localparam logic [1:0] QRW_HALF = 2'h0;
    localparam logic [1:0] QRW_07 = 2'h1;
    localparam logic [1:0] QRW_ONE = 2'h2;
    localparam logic [1:0] QRW_TWO = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEG_UNIT_NS = 100;      // deglitch step at code 001
    localparam int LOWP_STEP_NS = 100;     // low pulse step per code
    localparam int DCM_TRI_NS = 40000;     // tri-state before pull-down
    localparam int DEG_UNIT_CYC =
        (DEG_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOWP_STEP_CYC =
        (LOWP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DCM_TRI_CYC =
        (DCM_TRI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // deglitch code to cycles: zero, then doubling from one unit
    function automatic logic [7:0] deg_cycles(input logic [2:0] code);
        logic [7:0] base;
        base = 8'(DEG_UNIT_CYC);
        if (code == 3'h0) begin
            deg_cycles = 8'h00;
        end else begin
            deg_cycles = 8'(base << (code - 3'h1));
        end
    endfunction

endpackage

// file: rtl/tpsc_sync2.sv
module tpsc_sync2 #(
    parameter int W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // ----------------------------------------------------------------
    // two-stage synchroniser; first stage feeds only the second
    // ----------------------------------------------------------------
    logic [W-1:0] meta_q;  // first stage, read by sync_out only

    // capture comparator levels into the clock domain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: rtl/tpsc_oneshot.sv
module tpsc_oneshot #(
    parameter int LW = 10
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [LW-1:0] len,
    output logic busy_q
);

    // ----------------------------------------------------------------
    // pulse of len cycles, starting the cycle after start
    // ----------------------------------------------------------------
    logic [LW-1:0] cnt_q;  // cycles still to run
    logic [LW-1:0] cnt_d;

    // start reloads, otherwise count down to zero
    assign cnt_d = start ? len :
                   (cnt_q != '0) ? LW'(cnt_q - 1'b1) : '0;

    // counter and busy flag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= (cnt_d != '0);
        end
    end

    // a nonzero start always yields a busy pulse next cycle
    chk_oneshot_start: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (start && len != '0) |=> busy_q)
        else $error("one-shot did not start");

endmodule

// file: rtl/tpsc_cfg_regs.sv
module tpsc_cfg_regs #(
    parameter int PHASES = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic [7:0] lock_code,
    input wire logic power_state_input_override,
    input wire logic power_state_input_high,
    input wire logic power_state_input_mid,
    input wire logic quick_response_below_cmp,
    input wire logic ao_above_cmp,
    input wire logic [7:0] nominal_on_time_cycles,
    input wire logic [PHASES-1:0] phase_add,
    input wire logic discontinuous_conduction_mode,
    input wire logic pwm_tristate,
    input wire logic [PHASES-1:0] ocp_flag_raw,
    output logic [PHASES-1:0] hs_force_on,
    output logic [PHASES-1:0] pwm_low_force,
    output logic auto_phase_shedding_active,
    output logic ao_event,
    output logic [3:0] cbd_time_code,
    output logic [2:0] quick_response_threshold_code,
    output logic [2:0] ao_threshold_code,
    output logic [1:0] ref_filter_code,
    output logic [2:0] pd_ccm_code,
    output logic [1:0] pd_dcm_code,
    output logic pd_dcm_on,
    output logic ocp_analog_en,
    output logic ocp_trip
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] cbd_q;   // balance disable time
    logic [7:0] quick_q; // quick response / overshoot
    logic [7:0] shed_q;  // deglitch / low pulse
    logic [7:0] scr_q;   // scratch, no function
    logic [7:0] rfpd_q;  // reference filter / pull-down
    logic [7:0] ocp_q;   // overcurrent enables

    // ----------------------------------------------------------------
    // write qualification
    // ----------------------------------------------------------------
    wire unlocked = (lock_code != tpsc_pkg::LOCK_CODE);
    wire pwr_state_ok = power_state_input_high | power_state_input_override;
    wire gated_ok = unlocked & pwr_state_ok;
    wire wr_cbd = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_CBD) &
                  gated_ok;
    wire wr_quick = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_QUICK) &
                    unlocked;
    wire wr_shed = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_SHED) &
                   gated_ok;
    wire wr_scr = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_SCR) &
                  unlocked;
    wire wr_rfpd = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_RFPD) &
                   unlocked;
    wire wr_ocp = reg_wr_en & (reg_addr == tpsc_pkg::ADDR_OCP) &
                  unlocked;

    // register writes, reserved bits held at zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cbd_q <= tpsc_pkg::RST_CBD;
            quick_q <= tpsc_pkg::RST_QUICK;
            shed_q <= tpsc_pkg::RST_SHED;
            scr_q <= tpsc_pkg::RST_SCR;
            rfpd_q <= tpsc_pkg::RST_RFPD;
            ocp_q <= tpsc_pkg::RST_OCP;
        end else begin
            if (wr_cbd) begin
                cbd_q <= reg_wr_data & tpsc_pkg::MASK_CBD;
            end
            if (wr_quick) begin
                quick_q <= reg_wr_data & tpsc_pkg::MASK_QUICK;
            end
            if (wr_shed) begin
                shed_q <= reg_wr_data & tpsc_pkg::MASK_SHED;
            end
            if (wr_scr) begin
                scr_q <= reg_wr_data & tpsc_pkg::MASK_SCR;
            end
            if (wr_rfpd) begin
                rfpd_q <= reg_wr_data & tpsc_pkg::MASK_RFPD;
            end
            if (wr_ocp) begin
                ocp_q <= reg_wr_data & tpsc_pkg::MASK_OCP;
            end
        end
    end

    // ----------------------------------------------------------------
    // read port: registered, unmapped offsets read zero
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr == tpsc_pkg::ADDR_CBD) ? cbd_q :
                    (reg_addr == tpsc_pkg::ADDR_QUICK) ? quick_q :
                    (reg_addr == tpsc_pkg::ADDR_SHED) ? shed_q :
                    (reg_addr == tpsc_pkg::ADDR_SCR) ? scr_q :
                    (reg_addr == tpsc_pkg::ADDR_RFPD) ? rfpd_q :
                    (reg_addr == tpsc_pkg::ADDR_OCP) ? ocp_q : 8'h00;

    // read data updates only on a read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // field codes to the analog side, straight from storage
    // ----------------------------------------------------------------
    assign cbd_time_code = cbd_q[3:0];
    assign quick_response_threshold_code =
        quick_q[tpsc_pkg::QUICK_THR_LSB +: 3];
    assign ao_threshold_code = quick_q[tpsc_pkg::AO_THR_LSB +: 3];
    assign ref_filter_code = rfpd_q[tpsc_pkg::RF_LSB +: 2];
    assign pd_ccm_code = rfpd_q[tpsc_pkg::PD_CCM_LSB +: 3];
    assign pd_dcm_code = rfpd_q[tpsc_pkg::PD_DCM_LSB +: 2];
    assign ocp_analog_en = ocp_q[tpsc_pkg::OCP_ANA_BIT];

    // ----------------------------------------------------------------
    // comparator synchronisation
    // ----------------------------------------------------------------
    logic [2:0] cmp_s;  // {mid, overshoot, quick response}
    tpsc_sync2 #(.W(3)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({power_state_input_mid, ao_above_cmp,
                   quick_response_below_cmp}),
        .sync_out(cmp_s)
    );
    wire quick_s = cmp_s[0];
    wire ao_s = cmp_s[1];
    wire mid_s = cmp_s[2];

    // ----------------------------------------------------------------
    // quick-response pulse across all phases
    // ----------------------------------------------------------------
    logic quick_prev_q;   // last synchronised level, for edge detect
    logic quick_busy;     // one-shot output
    wire quick_start = quick_s & ~quick_prev_q;
    wire [11:0] ontime_w = {4'h0, nominal_on_time_cycles};
    wire [11:0] ontime_x7 = 12'(ontime_w * 12'h007);
    wire [1:0] quick_sel = quick_q[tpsc_pkg::QUICK_WIDTH_LSB +: 2];
    logic [9:0] quick_len;
    assign quick_len =
        (quick_sel == tpsc_pkg::QRW_HALF) ? 10'(ontime_w >> 1) :
        (quick_sel == tpsc_pkg::QRW_07) ? 10'(ontime_x7 / 12'h00A) :
        (quick_sel == tpsc_pkg::QRW_ONE) ? 10'(ontime_w) :
        10'(ontime_w << 1);

    tpsc_oneshot #(.LW(10)) u_quick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(quick_start),
        .len(quick_len),
        .busy_q(quick_busy)
    );

    // edge memory and overshoot event level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quick_prev_q <= 1'b0;
            ao_event <= 1'b0;
        end else begin
            quick_prev_q <= quick_s;
            ao_event <= ao_s;
        end
    end
    assign hs_force_on = {PHASES{quick_busy}};

    // ----------------------------------------------------------------
    // shedding entry deglitch
    // ----------------------------------------------------------------
    logic [7:0] mid_cnt_q;  // cycles the middle level has been held
    wire [7:0] deg_lim = tpsc_pkg::deg_cycles(
        shed_q[tpsc_pkg::DEG_LSB +: 3]);
    wire shed_act_d = mid_s & (auto_phase_shedding_active |
                               (mid_cnt_q >= deg_lim));

    // counter saturates; any departure from middle restarts it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mid_cnt_q <= 8'h00;
            auto_phase_shedding_active <= 1'b0;
        end else begin
            mid_cnt_q <= !mid_s ? 8'h00 :
                         (mid_cnt_q == 8'hFF) ? mid_cnt_q :
                         8'(mid_cnt_q + 8'h01);
            auto_phase_shedding_active <= shed_act_d;
        end
    end

    // ----------------------------------------------------------------
    // low pulse for each phase added while shedding is active
    // ----------------------------------------------------------------
    wire [9:0] lowp_len = 10'(shed_q[tpsc_pkg::LOWP_LSB +: 3] *
                              tpsc_pkg::LOWP_STEP_CYC);
    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi = gi + 1) begin : g_lowp
            tpsc_oneshot #(.LW(10)) u_lowp (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .start(phase_add[gi] & auto_phase_shedding_active),
                .len(lowp_len),
                .busy_q(pwm_low_force[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // discontinuous pull-down timer and overcurrent flag
    // ----------------------------------------------------------------
    localparam logic [9:0] DCM_LIM = 10'(tpsc_pkg::DCM_TRI_CYC);
    logic [9:0] tri_cnt_q;  // cycles of tri-state in discontinuous mode
    wire tri_on = discontinuous_conduction_mode & pwm_tristate;
    wire [9:0] tri_cnt_d = !tri_on ? 10'h000 :
                           (tri_cnt_q == DCM_LIM) ? tri_cnt_q :
                           10'(tri_cnt_q + 10'h001);
    wire flag_en = ocp_q[tpsc_pkg::OCP_FLAG_BIT];

    // pull-down applies once tri-state outlasts the limit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tri_cnt_q <= 10'h000;
            pd_dcm_on <= 1'b0;
            ocp_trip <= 1'b0;
        end else begin
            tri_cnt_q <= tri_cnt_d;
            pd_dcm_on <= tri_on & (tri_cnt_d == DCM_LIM);
            ocp_trip <= flag_en & (|ocp_flag_raw);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_cbd_write_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && reg_addr == tpsc_pkg::ADDR_CBD && !gated_ok)
        |=> $stable(cbd_q))
        else $error("balance time changed while gated");
    chk_quick_lock_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && reg_addr == tpsc_pkg::ADDR_QUICK && !unlocked)
        |=> $stable(quick_q))
        else $error("quick response register written while locked");
    chk_shed_write_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && reg_addr == tpsc_pkg::ADDR_SHED && gated_ok)
        |=> shed_q == ($past(reg_wr_data) & tpsc_pkg::MASK_SHED))
        else $error("shedding register missed an allowed write");
    chk_scratch_lock: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && reg_addr == tpsc_pkg::ADDR_SCR && !unlocked)
        |=> $stable(scr_q))
        else $error("scratch written while locked");
    chk_rfpd_ocp_lock: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && !unlocked) |=> ($stable(rfpd_q) && $stable(ocp_q)))
        else $error("filter or overcurrent register written while locked");
    chk_quick_force_all: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (quick_start && quick_len != 10'h000) |=>
        hs_force_on == {PHASES{1'b1}})
        else $error("quick response did not force all high sides");
    chk_shed_after_mid: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(auto_phase_shedding_active) |->
        $past(mid_s) && ($past(mid_cnt_q) >= $past(deg_lim)))
        else $error("shedding entered before deglitch time");
    chk_dcm_pd_wait: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pd_dcm_on |-> tri_cnt_q == DCM_LIM)
        else $error("discontinuous pull-down applied too early");

endmodule

// file: tb/tpsc_cfg_regs_tb_top.sv
module tpsc_cfg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] lock_code = 8'h00;
    logic ps_ovr = 1'b0;
    logic ps_hi = 1'b0;
    logic ps_mid = 1'b0;
    logic quick_cmp = 1'b0;
    logic ao_cmp = 1'b0;
    logic dcm = 1'b0;
    logic tri_st = 1'b0;
    logic [7:0] ontime = 8'h0A; // nominal on-time of 10 cycles
    logic [7:0] phase_add = 8'h00;
    logic [7:0] ocp_raw = 8'h00;
    logic [7:0] reg_rd_data, hs_on, low_force;
    logic shed_on, ao_ev, dcm_on, ocp_an, ocp_trip;
    logic [3:0] cbd;
    logic [2:0] quick_thr, ao_thr, pd_ccm;
    logic [1:0] rf, pd_dcm;
    int n_mismatch = 0;
    int compares = 0;
    int n, i, c;
    logic [7:0] d;

    // one write row: target, data, lock, power-state gate, override, readback
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic lock;
        logic hi;
        logic ovr;
        logic [7:0] exp;
    } tpsc_row_type;
    tpsc_row_type rows [0:16] = '{
        '{8'h49, 8'hFF, 1'b0, 1'b0, 1'b0, 8'hFF},
        '{8'h49, 8'h00, 1'b1, 1'b1, 1'b1, 8'hFF},
        '{8'h48, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h0B},
        '{8'h48, 8'hF5, 1'b0, 1'b1, 1'b0, 8'h05},
        '{8'h48, 8'h0A, 1'b0, 1'b0, 1'b1, 8'h0A},
        '{8'h48, 8'h03, 1'b1, 1'b1, 1'b1, 8'h0A},
        '{8'h4A, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h13},
        '{8'h4A, 8'hFF, 1'b0, 1'b0, 1'b1, 8'h3F},
        '{8'h4A, 8'h00, 1'b1, 1'b1, 1'b1, 8'h3F},
        '{8'h4A, 8'h12, 1'b0, 1'b1, 1'b0, 8'h12},
        '{8'h4B, 8'hA5, 1'b0, 1'b0, 1'b0, 8'hA5},
        '{8'h4B, 8'h5A, 1'b1, 1'b0, 1'b0, 8'hA5},
        '{8'h4C, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h7F},
        '{8'h4C, 8'h00, 1'b1, 1'b0, 1'b0, 8'h7F},
        '{8'h4D, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h03},
        '{8'h4D, 8'h00, 1'b1, 1'b0, 1'b0, 8'h03},
        '{8'h50, 8'hFF, 1'b0, 1'b0, 1'b0, 8'h00}
    };
    logic [7:0] width_exp [0:3] = '{8'h05, 8'h07, 8'h0A, 8'h14};
    logic [7:0] rst_val [0:5] = '{8'h0B, 8'h5B, 8'h13, 8'h00, 8'h2A, 8'h00};

    // ----------------------------------------------------------------
    // design under test
    // ----------------------------------------------------------------
    tpsc_cfg_regs #(.PHASES(8)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .lock_code(lock_code), .power_state_input_override(ps_ovr),
        .power_state_input_high(ps_hi), .power_state_input_mid(ps_mid),
        .quick_response_below_cmp(quick_cmp), .ao_above_cmp(ao_cmp),
        .nominal_on_time_cycles(ontime), .phase_add(phase_add),
        .discontinuous_conduction_mode(dcm), .pwm_tristate(tri_st),
        .ocp_flag_raw(ocp_raw), .hs_force_on(hs_on),
        .pwm_low_force(low_force), .auto_phase_shedding_active(shed_on),
        .ao_event(ao_ev), .cbd_time_code(cbd),
        .quick_response_threshold_code(quick_thr),
        .ao_threshold_code(ao_thr), .ref_filter_code(rf),
        .pd_ccm_code(pd_ccm), .pd_dcm_code(pd_dcm), .pd_dcm_on(dcm_on),
        .ocp_analog_en(ocp_an), .ocp_trip(ocp_trip)
    );

    // free-running 50 ns clock
    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // compare and count, report a mismatch at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= dt;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask

    // one-cycle read strobe, data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(negedge sys_clk);
        dt = reg_rd_data;
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 1200 cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // table of writes, locked and unlocked, with the gate closed or opened by high, override or both
        for (i = 0; i < 17; i++) begin
            @(posedge sys_clk);
            lock_code <= rows[i].lock ? tpsc_pkg::LOCK_CODE : 8'hA7;
            ps_hi <= rows[i].hi;
            ps_ovr <= rows[i].ovr;
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, d);
            chk(32'(d), 32'(rows[i].exp));
        end
        chk({cbd, quick_thr, ao_thr, rf, pd_ccm, pd_dcm, ocp_an},
            {4'hA, 3'h7, 3'h7, 2'h3, 3'h7, 2'h3, 1'b1});
        // every pulse width code against a 10-cycle on-time
        for (c = 0; c < 4; c++) begin
            wr(tpsc_pkg::ADDR_QUICK, {c[1:0], 6'h1B});
            @(posedge sys_clk);
            quick_cmp <= 1'b1;
            n = 0;
            repeat (40) begin
                @(negedge sys_clk);
                if (hs_on === 8'hFF) n++;
            end
            @(posedge sys_clk);
            quick_cmp <= 1'b0;
            repeat (4) @(posedge sys_clk);
            chk(n, 32'(width_exp[c]));
        end
        // overshoot comparator reaches the event output
        @(posedge sys_clk);
        ao_cmp <= 1'b1;
        repeat (5) @(negedge sys_clk);
        chk(ao_ev, 1);
        @(posedge sys_clk);
        ao_cmp <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(ao_ev, 0);
        // middle level shorter than the 4-cycle deglitch is ignored
        @(posedge sys_clk);
        ps_mid <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ps_mid <= 1'b0;
        n = 0;
        repeat (10) begin
            @(negedge sys_clk);
            if (shed_on === 1'b1) n++;
        end
        chk(n, 0);
        // held middle level enters shedding after sync plus deglitch
        @(posedge sys_clk);
        ps_mid <= 1'b1;
        n = 0;
        while (shed_on !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk(32'(n >= 6 && n <= 9), 1);
        // added phase gives a low pulse of code 2, i.e. 4 cycles
        for (c = 0; c < 2; c++) begin
            @(posedge sys_clk);
            phase_add <= 8'h08;
            @(posedge sys_clk);
            phase_add <= 8'h00;
            n = 0;
            repeat (12) begin
                @(negedge sys_clk);
                if (low_force === 8'h08) n++;
            end
            chk(n, (c == 0) ? 4 : 0);
            @(posedge sys_clk);
            ps_mid <= 1'b0;
            repeat (6) @(negedge sys_clk);
        end
        // tri-state must persist 800 cycles before the pull-down applies
        @(posedge sys_clk);
        dcm <= 1'b1;
        tri_st <= 1'b1;
        repeat (800) @(negedge sys_clk);
        chk(dcm_on, 0);
        @(negedge sys_clk);
        chk(dcm_on, 1);
        @(posedge sys_clk);
        tri_st <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(dcm_on, 0);
        // flag enable and analog enable drive the overcurrent outputs
        @(posedge sys_clk);
        ocp_raw <= 8'h10;
        repeat (3) @(negedge sys_clk);
        chk(ocp_trip, 1);
        wr(tpsc_pkg::ADDR_OCP, 8'h02);
        repeat (3) @(negedge sys_clk);
        chk({ocp_an, ocp_trip}, 2'b10);
        // second reset in mid-run restores every register
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(8'(8'h48 + i), d);
            chk(d, rst_val[i]);
        end
        chk({cbd, quick_thr, ao_thr, rf, pd_ccm, pd_dcm, ocp_an},
            {4'hB, 3'h3, 3'h3, 2'h1, 3'h2, 2'h2, 1'b0});
        chk({rf, pd_ccm, pd_dcm}, 7'h2A);
        tally_and_finish();
    end
endmodule
